//--- card_timing_consts.svh
// offsets, reset values and timing counts of the card cycle sequencer
`ifndef CARD_TIMING_CONSTS_SVH
`define CARD_TIMING_CONSTS_SVH
`define SETUP_TIME_SET0_IDX     8'h3A
`define COMMAND_TIME_SET0_IDX   8'h3B
`define RECOVERY_TIME_SET0_IDX  8'h3C
`define SETUP_TIME_SET1_IDX     8'h3D
`define COMMAND_TIME_SET1_IDX   8'h3E
`define RECOVERY_TIME_SET1_IDX  8'h3F
`define WINDOW_SELECT_IDX       8'h40
`define CYCLE_STATUS_IDX        8'h41
`define SETUP_TIME_SET0_RST     8'h01
`define COMMAND_TIME_SET0_RST   8'h05
`define RECOVERY_TIME_SET0_RST  8'h00
`define SET1_RST                8'h00
`define PRESCALER_LSB           6
`define MULTIPLIER_W            6
`define WIDE_FLAG_WAIT          8'h03
`define WIDE_FLAG_SYNC          8'h03
`endif

//--- card_timing_pkg.sv
// types of the card cycle sequencer
package card_timing_pkg;
	typedef struct packed {
		logic [7:0] setup;
		logic [7:0] command;
		logic [7:0] recovery;
	} timer_set_t;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_PROBE   = 3'b001,
		ST_SETUP   = 3'b010,
		ST_COMMAND = 3'b011,
		ST_RECOVER = 3'b100
	} phase_t;
	typedef struct packed {
		logic        valid;
		logic [25:0] addr;
		logic        is_io;
		logic        is_write;
		logic        wide_host;
		logic        odd_byte;
		logic        window;
	} cycle_req_t;
	typedef struct packed {
		logic en_low_n;
		logic en_high_n;
		logic cmd_n;
		logic [25:0] addr;
	} card_pins_t;
endpackage

//--- phase_count.sv
// one phase length: prescale times multiplier plus one
`timescale 1ns/10ps
`include "card_timing_consts.svh"
module phase_count
	import card_timing_pkg::*;
(
	// timing register
	input  wire logic [7:0]  timing,
	// resulting period count
	output logic      [15:0] periods
);
	// prescaler select picks 1,16,256,4096, expressed by shift
	always_comb begin
		unique case (timing[7:`PRESCALER_LSB])
			2'b00: periods = 16'(timing[5:0]) + 16'h0001;
			2'b01: periods = (16'(timing[5:0]) << 4) + 16'h0001;
			2'b10: periods = (16'(timing[5:0]) << 8) + 16'h0001;
			2'b11: periods = (16'(timing[3:0]) << 12) + 16'h0001;
		endcase
	end
endmodule

//--- timing_regs.sv
// axi4-lite slave holding the timer sets
`timescale 1ns/10ps
`include "card_timing_consts.svh"
module timing_regs
	import card_timing_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite
	input  wire logic [9:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [9:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// to sequencer
	output timer_set_t       set0,
	output timer_set_t       set1,
	output logic [1:0]       window_set,
	input  wire logic [7:0]  status
);
	typedef struct packed {
		timer_set_t  s0;
		timer_set_t  s1;
		logic [1:0]  win;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  aw_idx;
		logic [7:0]  wd;
		logic        w_en;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
	} regs_t;
	regs_t q, d;
	logic [7:0] ar_idx;
	logic       hit;
	assign ar_idx = araddr[9:2];
	assign awready = !q.aw_got && !q.bv;
	assign wready  = !q.w_got && !q.bv;
	assign arready = !q.rv;
	// next state of slave and registers
	always_comb begin
		d = q;
		hit = 1'b1;
		if (awvalid && awready) begin
			d.aw_got = 1'b1;
			d.aw_idx = awaddr[9:2];
		end
		if (wvalid && wready) begin
			d.w_got = 1'b1;
			d.wd = wdata[7:0];
			d.w_en = wstrb[0];
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bv = 1'b1;
			d.br = 2'b00;
			unique case (q.aw_idx)
				`SETUP_TIME_SET0_IDX:    if (q.w_en) d.s0.setup = q.wd;
				`COMMAND_TIME_SET0_IDX:  if (q.w_en) d.s0.command = q.wd;
				`RECOVERY_TIME_SET0_IDX: if (q.w_en) d.s0.recovery = q.wd;
				`SETUP_TIME_SET1_IDX:    if (q.w_en) d.s1.setup = q.wd;
				`COMMAND_TIME_SET1_IDX:  if (q.w_en) d.s1.command = q.wd;
				`RECOVERY_TIME_SET1_IDX: if (q.w_en) d.s1.recovery = q.wd;
				`WINDOW_SELECT_IDX:      if (q.w_en) d.win = q.wd[1:0];
				`CYCLE_STATUS_IDX:       d.br = 2'b00;
				default:                 d.br = 2'b10;
			endcase
		end
		if (q.bv && bready)
			d.bv = 1'b0;
		if (arvalid && arready) begin
			d.rv = 1'b1;
			d.rd = 32'h0000_0000;
			unique case (ar_idx)
				`SETUP_TIME_SET0_IDX:    d.rd[7:0] = q.s0.setup;
				`COMMAND_TIME_SET0_IDX:  d.rd[7:0] = q.s0.command;
				`RECOVERY_TIME_SET0_IDX: d.rd[7:0] = q.s0.recovery;
				`SETUP_TIME_SET1_IDX:    d.rd[7:0] = q.s1.setup;
				`COMMAND_TIME_SET1_IDX:  d.rd[7:0] = q.s1.command;
				`RECOVERY_TIME_SET1_IDX: d.rd[7:0] = q.s1.recovery;
				`WINDOW_SELECT_IDX:      d.rd[1:0] = q.win;
				`CYCLE_STATUS_IDX:       d.rd[7:0] = status;
				default:                 hit = 1'b0;
			endcase
			d.rr = hit ? 2'b00 : 2'b10;
		end else if (q.rv && rready)
			d.rv = 1'b0;
	end
	// register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.s0.setup <= `SETUP_TIME_SET0_RST;
			q.s0.command <= `COMMAND_TIME_SET0_RST;
			q.s0.recovery <= `RECOVERY_TIME_SET0_RST;
			q.s1 <= {`SET1_RST, `SET1_RST, `SET1_RST};
		end else
			q <= d;
	end
	assign bvalid = q.bv;
	assign bresp = q.br;
	assign rvalid = q.rv;
	assign rdata = q.rd;
	assign rresp = q.rr;
	assign set0 = q.s0;
	assign set1 = q.s1;
	assign window_set = q.win;
endmodule

//--- card_cycle_timing_sequencer.sv
// card side sequencer of setup, command and recovery phases
`timescale 1ns/10ps
`include "card_timing_consts.svh"
// Function
// - address and enables held S periods before command strobe; set 0 setup resets 01h
// - command strobe held C periods; set 0 command resets 05h
// - address held R periods after strobe ends; set 0 recovery resets 00h
// - odd byte to 8-bit card: drop high-byte enable when wide flag inactive
// - same case: raise low-byte enable then run programmed phases
// - all other byte accesses use plain setup, command, recovery
// - wide flag not low within three periods is ignored; high enable stays off
module card_cycle_timing_sequencer
	import card_timing_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite register bus
	input  wire logic [9:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [9:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// cycle request from window logic
	input  cycle_req_t       req,
	output logic             req_ready,
	output logic             cycle_done,
	// card pins
	input  wire logic        card_io_wide_flag_n,
	output card_pins_t       pins,
	output logic             cmd_read_n,
	output logic             cmd_write_n
);
	timer_set_t set0, set1, sel;
	logic [1:0]  window_set;
	logic [7:0]  status;
	logic [15:0] s_per, c_per, r_per;
	typedef struct packed {
		phase_t      st;
		logic [15:0] cnt;
		logic [15:0] c_len;
		logic [15:0] r_len;
		logic [15:0] s_len;
		logic [15:0] age;
		logic [7:0]  probe;
		logic        odd8;
		logic        write;
		logic [2:0]  sync;
		logic        wide_seen;
		card_pins_t  p;
		logic        done;
	} seq_t;
	seq_t q, d;
	logic wide_low;
	timing_regs u_regs (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.awaddr     (awaddr),
		.awvalid    (awvalid),
		.awready    (awready),
		.wdata      (wdata),
		.wstrb      (wstrb),
		.wvalid     (wvalid),
		.wready     (wready),
		.bresp      (bresp),
		.bvalid     (bvalid),
		.bready     (bready),
		.araddr     (araddr),
		.arvalid    (arvalid),
		.arready    (arready),
		.rdata      (rdata),
		.rresp      (rresp),
		.rvalid     (rvalid),
		.rready     (rready),
		.set0       (set0),
		.set1       (set1),
		.window_set (window_set),
		.status     (status)
	);
	// timer set chosen by the request window
	assign sel = window_set[req.window] ? set1 : set0;
	phase_count u_setup (.timing(sel.setup), .periods(s_per));
	phase_count u_cmd (.timing(sel.command), .periods(c_per));
	phase_count u_rec (.timing(sel.recovery), .periods(r_per));
	// flag counts low once second and third stage agree
	assign wide_low = !q.sync[1] && !q.sync[2];
	assign req_ready = (q.st == ST_IDLE);
	assign status = {4'h0, q.wide_seen, q.st};
	// sequencer next state
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.sync = {q.sync[1:0], card_io_wide_flag_n};
		unique case (q.st)
			ST_IDLE: begin
				if (req.valid) begin
					d.p.addr = req.addr;
					d.write = req.is_write;
					d.c_len = c_per;
					d.r_len = r_per;
					d.s_len = s_per;
					d.odd8 = req.is_io && req.wide_host && req.odd_byte;
					d.probe = 8'h00;
					d.wide_seen = 1'b0;
					if (d.odd8) begin
						// high enable for the odd byte until the card answers
						d.p.en_high_n = 1'b0;
						d.p.en_low_n = 1'b1;
						d.st = ST_PROBE;
					end else begin
						d.p.en_low_n = req.odd_byte;
						d.p.en_high_n = !req.odd_byte;
						d.cnt = s_per;
						d.st = ST_SETUP;
					end
				end
			end
			ST_PROBE: begin
				d.probe = q.probe + 8'h01;
				if (wide_low) begin
					// card is 16 bit: plain sequence on high enable
					d.wide_seen = 1'b1;
					d.cnt = q.s_len;
					d.st = ST_SETUP;
				end else if (q.probe >= (`WIDE_FLAG_WAIT + `WIDE_FLAG_SYNC)) begin
					// flag inactive after card time plus sync stages: move to low byte enable
					d.p.en_high_n = 1'b1;
					d.p.en_low_n = 1'b0;
					d.cnt = q.s_len;
					d.st = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (q.cnt <= 16'h0001) begin
					d.p.cmd_n = 1'b0;
					d.cnt = q.c_len;
					d.st = ST_COMMAND;
				end else
					d.cnt = q.cnt - 16'h0001;
			end
			ST_COMMAND: begin
				if (q.cnt <= 16'h0001) begin
					d.p.cmd_n = 1'b1;
					d.cnt = q.r_len;
					d.st = ST_RECOVER;
				end else
					d.cnt = q.cnt - 16'h0001;
			end
			ST_RECOVER: begin
				if (q.cnt <= 16'h0001) begin
					d.p.en_low_n = 1'b1;
					d.p.en_high_n = 1'b1;
					d.done = 1'b1;
					d.st = ST_IDLE;
				end else
					d.cnt = q.cnt - 16'h0001;
			end
			default: d.st = ST_IDLE;
		endcase
		// cycles spent in the current phase, for the length checks
		d.age = (d.st == q.st) ? q.age + 16'h0001 : 16'h0000;
	end
	// register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.sync <= 3'b111;
			q.p.en_low_n <= 1'b1;
			q.p.en_high_n <= 1'b1;
			q.p.cmd_n <= 1'b1;
		end else
			q <= d;
	end
	assign pins = q.p;
	assign cmd_read_n = q.p.cmd_n | q.write;
	assign cmd_write_n = q.p.cmd_n | !q.write;
	assign cycle_done = q.done;
	// setup phase loaded with a count of 2 lasts exactly two cycles
	a_setup_length: assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(q.st == ST_SETUP) && q.cnt == 16'h0002) |=> ##1 (q.st == ST_COMMAND))
		else $error("setup length wrong");
	// strobe low through command phase
	a_strobe_held: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_COMMAND) |-> !q.p.cmd_n)
		else $error("strobe not held");
	// strobe high in recovery with address held
	a_recovery_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_RECOVER) |-> (q.p.cmd_n && $stable(q.p.addr)))
		else $error("recovery hold broken");
	// odd byte swap of enables after timeout
	a_odd_swap: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_PROBE && !wide_low && q.probe >= (`WIDE_FLAG_WAIT + `WIDE_FLAG_SYNC))
		|=> (q.p.en_high_n && !q.p.en_low_n))
		else $error("enable swap missing");
	// low enable active before setup ends in odd case
	a_low_setup: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_SETUP && q.odd8 && !q.wide_seen) |-> !q.p.en_low_n)
		else $error("low enable inactive");
	// probe bounded by wait plus sync count, left within seven cycles
	a_probe_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(q.st == ST_PROBE) |-> ##[1:7] (q.st != ST_PROBE))
		else $error("probe too long");
	// normal cycle skips probe
	a_plain_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_IDLE && req.valid && !(req.is_io && req.wide_host && req.odd_byte)) |=> (q.st == ST_SETUP))
		else $error("plain cycle probed");
	// command length loaded from chosen set
	a_set_load: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_IDLE && req.valid) |=> (q.c_len == $past(c_per)))
		else $error("timer set not loaded");
	// phase ends, as seen by the next state
	sequence s_setup_end;
		q.st == ST_SETUP && d.st == ST_COMMAND;
	endsequence
	sequence s_command_end;
		q.st == ST_COMMAND && d.st == ST_RECOVER;
	endsequence
	sequence s_recovery_end;
		q.st == ST_RECOVER && d.st == ST_IDLE;
	endsequence
	// cycle starts at the request port
	sequence s_take;
		q.st == ST_IDLE && req.valid;
	endsequence
	sequence s_odd_take;
		q.st == ST_IDLE && req.valid && req.is_io && req.wide_host && req.odd_byte;
	endsequence
	// setup length counted independently of the down counter
	a_setup_count: assert property (@(posedge aclk) disable iff (!aresetn)
		s_setup_end |-> (q.age + 16'h0001 == q.s_len))
		else $error("setup count wrong");
	// command length counted independently
	a_command_count: assert property (@(posedge aclk) disable iff (!aresetn)
		s_command_end |-> (q.age + 16'h0001 == q.c_len))
		else $error("command count wrong");
	// recovery length counted independently
	a_recovery_count: assert property (@(posedge aclk) disable iff (!aresetn)
		s_recovery_end |-> (q.age + 16'h0001 == q.r_len))
		else $error("recovery count wrong");
	// done pulse and enables released right after recovery
	a_done_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		s_recovery_end |=> (cycle_done && q.p.en_low_n && q.p.en_high_n))
		else $error("done not after recovery");
	// done lasts one cycle
	a_done_single: assert property (@(posedge aclk) disable iff (!aresetn)
		cycle_done |=> !cycle_done)
		else $error("done too long");
	// no strobe or enable while idle
	a_idle_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_IDLE) |-> (q.p.cmd_n && q.p.en_low_n && q.p.en_high_n))
		else $error("pins active while idle");
	// strobe only in command phase
	a_strobe_phase: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st != ST_COMMAND) |-> q.p.cmd_n)
		else $error("strobe outside command");
	// address held from cycle start to done
	a_addr_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st != ST_IDLE && $past(q.st) != ST_IDLE) |-> $stable(q.p.addr))
		else $error("address moved in cycle");
	// direction held through the cycle
	a_dir_held: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st != ST_IDLE && $past(q.st) != ST_IDLE) |-> $stable(q.write))
		else $error("direction moved in cycle");
	// odd byte start drives high enable alone
	a_probe_start: assert property (@(posedge aclk) disable iff (!aresetn)
		s_odd_take |=> (q.st == ST_PROBE && !q.p.en_high_n && q.p.en_low_n && q.probe == 8'h00))
		else $error("probe start wrong");
	// a low flag in probe leads to the plain sequence
	a_wide_detect: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_PROBE && wide_low) |=> (q.st == ST_SETUP && q.wide_seen))
		else $error("wide flag missed");
	// wide card keeps high enable through the cycle
	a_wide_plain: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st != ST_IDLE && q.wide_seen) |-> (!q.p.en_high_n && q.p.en_low_n))
		else $error("wide cycle enables wrong");
	// flag ignored: high enable stays off after the swap
	a_narrow_high_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st != ST_IDLE && q.st != ST_PROBE && q.odd8 && !q.wide_seen) |-> q.p.en_high_n)
		else $error("high enable after swap");
	// odd narrow command runs on low enable
	a_cmd_enables: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ST_COMMAND && q.odd8 && !q.wide_seen) |-> (!q.p.en_low_n && q.p.en_high_n))
		else $error("odd command enables wrong");
	// plain cycles drive exactly one enable
	a_enable_single: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st != ST_IDLE && !q.odd8) |-> (q.p.en_low_n != q.p.en_high_n))
		else $error("plain cycle enables wrong");
	// setup and recovery lengths loaded at cycle start
	a_set_lengths: assert property (@(posedge aclk) disable iff (!aresetn)
		s_take |=> (q.s_len == $past(s_per) && q.r_len == $past(r_per)))
		else $error("phase lengths not loaded");
endmodule

//--- card_model.sv
// socket card model driving the 16-bit i/o flag
`timescale 1ns/10ps
module card_model
	import card_timing_pkg::*;
(
	// clock
	input  wire logic aclk,
	// pins from the sequencer
	input  card_pins_t pins,
	// card reports 16-bit i/o
	input  wire logic wide,
	// flag back to the sequencer
	output logic      card_io_wide_flag_n
);
	logic [25:0] addr_q = 26'h0;
	logic        sel_q  = 1'h0;
	logic        wait_q = 1'h0;
	logic        sel;
	initial card_io_wide_flag_n = 1'h1;
	assign sel = !(pins.en_low_n && pins.en_high_n);
	// flag unsettled for a while after an address change, settled by the third period
	always @(posedge aclk) begin
		addr_q <= pins.addr;
		sel_q  <= sel;
		if ((pins.addr != addr_q) || (sel && !sel_q)) begin
			wait_q              <= 1'($urandom_range(1));
			card_io_wide_flag_n <= !card_io_wide_flag_n;
		end else if (!sel || wait_q) begin
			wait_q              <= 1'h0;
			card_io_wide_flag_n <= !card_io_wide_flag_n; // not driven: changes every cycle
		end else begin
			card_io_wide_flag_n <= !wide;
		end
	end
endmodule

//--- test_card_cycle_timing_sequencer.sv
// self-checking testbench of the card cycle sequencer
`timescale 1ns/10ps
`include "card_timing_consts.svh"
module test_card_cycle_timing_sequencer
	import card_timing_pkg::*;
;
	logic        aclk = 1'h0, aresetn = 1'h0, card_wide = 1'h0;
	logic [9:0]  awaddr = 10'h0, araddr = 10'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, req_ready, cycle_done;
	logic        card_io_wide_flag_n, cmd_read_n, cmd_write_n;
	cycle_req_t  req = '0;
	card_pins_t  pins;
	int          n_errors = 0, cmp_count = 0;

	always #25 aclk = ~aclk;

	card_cycle_timing_sequencer u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .req, .req_ready, .cycle_done, .card_io_wide_flag_n, .pins, .cmd_read_n,
		.cmd_write_n);
	card_model u_card (.aclk, .pins, .wide(card_wide), .card_io_wide_flag_n);

	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic hang();
		n_errors++;
		$display("Error wait expected answer seen none");
		test_done();
	endtask
	// compares of bus values and of cycle counts
	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic chk_cnt(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// periods of one phase: prescale times multiplier plus one
	function automatic logic [15:0] periods(input logic [7:0] t);
		return (16'h1 << (4 * t[7:6])) * t[5:0] + 16'h1;
	endfunction
	// axi4-lite write; ready sampled at negedge, valid released at next rising edge
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
		logic ta, tw, tb;
		logic [1:0] resp;
		int k;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		k = 0;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) bready <= 1'h0;
			k++;
		end while (!tb && k < 100);
		if (!tb) hang();
		chk_val("bresp", {30'h0, exp}, {30'h0, resp});
	endtask
	task automatic axi_rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] exp_r);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] resp;
		int k;
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		k = 0;
		do begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'h0;
			if (tr) rready <= 1'h0;
			k++;
		end while (!tr && k < 100);
		if (!tr) hang();
		chk_val("rdata", {24'h0, exp}, d);
		chk_val("rresp", {30'h0, exp_r}, {30'h0, resp});
	endtask
	// one card cycle: phase lengths, enables at command, address and direction held
	task automatic run_cycle(input cycle_req_t r, input logic [15:0] s, c, rc, input logic eh, el);
		logic [15:0] ns, nc, nr;
		logic [1:0]  en_prev, en_cmd;
		logic        ok, seen;
		int k;
		@(posedge aclk);
		req <= r;
		k = 0;
		do begin
			@(negedge aclk);
			seen = req_ready;
			@(posedge aclk);
			k++;
		end while (!seen && k < 300);
		if (!seen) hang();
		req.valid <= 1'h0;
		ns = 0; nc = 0; nr = 0; en_prev = 2'h3; en_cmd = 2'h3; ok = 1'h1; seen = 1'h0; k = 0;
		do begin
			@(negedge aclk);
			if (ns > 0 || nc > 0) ok &= (pins.addr === r.addr);
			if (pins.cmd_n === 1'h0) begin
				nc++;
				en_cmd = {pins.en_high_n, pins.en_low_n};
				ok &= (cmd_read_n === r.is_write) && (cmd_write_n === !r.is_write);
			end else if (nc == 0) begin
				if ({pins.en_high_n, pins.en_low_n} != en_prev) ns = 0;
				if (!(pins.en_high_n && pins.en_low_n)) ns++;
				en_prev = {pins.en_high_n, pins.en_low_n};
			end else if (!(pins.en_high_n && pins.en_low_n)) begin
				nr++; // recovery only while the card is still enabled
			end
			seen = cycle_done;
			k++;
		end while (!seen && k < 2000);
		if (!seen) hang();
		chk_cnt("setup", s, (r.odd_byte && ns > s) ? s : ns);
		chk_cnt("command", c, nc);
		chk_cnt("recovery", rc, nr);
		chk_val("enables", {30'h0, eh, el}, {30'h0, en_cmd});
		chk_val("held", 32'h1, {31'h0, ok});
	endtask

	initial begin
		logic [7:0] t [3];
		cycle_req_t q;
		void'($urandom(32'h2ACD1C91));
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		// reset values, unmapped place
		axi_rd(`SETUP_TIME_SET0_IDX, `SETUP_TIME_SET0_RST, 2'h0);
		axi_rd(`COMMAND_TIME_SET0_IDX, `COMMAND_TIME_SET0_RST, 2'h0);
		axi_rd(`RECOVERY_TIME_SET0_IDX, `RECOVERY_TIME_SET0_RST, 2'h0);
		axi_rd(`RECOVERY_TIME_SET1_IDX, `SET1_RST, 2'h0);
		axi_rd(8'hFF, 8'h00, 2'h2);
		axi_wr(8'hFF, 8'h5A, 2'h2);
		// default timer set 0, plain byte cycle
		q = '0;
		q.valid = 1'h1;
		q.addr = 26'h2AAAAAA;
		run_cycle(q, 16'h2, 16'h6, 16'h1, 1'h1, 1'h0);
		axi_wr(`WINDOW_SELECT_IDX, 8'h02, 2'h0);
		axi_rd(`WINDOW_SELECT_IDX, 8'h02, 2'h0);
		// random set 1 timings, windows alternating from cycle to cycle
		for (int i = 0; i < 8; i++) begin
			foreach (t[j]) begin
				t[j] = {1'h0, 1'($urandom_range(1)), 6'($urandom_range(7))};
				axi_wr(8'(`SETUP_TIME_SET1_IDX + j), t[j], 2'h0);
				axi_rd(8'(`SETUP_TIME_SET1_IDX + j), t[j], 2'h0);
			end
			q.addr = 26'($urandom);
			q.is_write = 1'($urandom);
			q.is_io = 1'($urandom);
			q.window = i[0];
			run_cycle(q, periods(q.window ? t[0] : `SETUP_TIME_SET0_RST),
				periods(q.window ? t[1] : `COMMAND_TIME_SET0_RST),
				periods(q.window ? t[2] : `RECOVERY_TIME_SET0_RST), 1'h1, 1'h0);
		end
		// odd byte from a wide host to an 8-bit card, then to a 16-bit card
		q.window = 1'h0;
		q.is_io = 1'h1;
		q.odd_byte = 1'h1;
		q.wide_host = 1'h1;
		card_wide <= 1'h0;
		run_cycle(q, 16'h2, 16'h6, 16'h1, 1'h1, 1'h0);
		card_wide <= 1'h1;
		q.addr = q.addr ^ 26'h3;
		run_cycle(q, 16'h2, 16'h6, 16'h1, 1'h0, 1'h1);
		axi_rd(`CYCLE_STATUS_IDX, 8'h08, 2'h0);
		test_done();
	end
endmodule
